/* rtl/cfmc_top.v */
// Function
// RULE_01: The transmit gap code inserts 0, 2..2048 doubling, or 4096 bit times between transmissions.
// RULE_02: Writing 1 to abort bit 27 tells all transmit buffers to abort; software cannot clear it.
// RULE_03: Hardware clears the abort bit only once no transmission is pending any more.
// RULE_04: Mode request codes 111..000 select restricted, classic, ext loop, config, listen, int loop, off, FD.
// RULE_05: Classic-only mode answers received FD frames with an error frame.
// RULE_06: Normal FD mode accepts and sends FD and classic frames mixed.
// RULE_07: Configuration-only fields change only while the status shows configuration mode.
// RULE_08: The second controller's control register resets to 0x04980760.
// RULE_09: The nominal bit-timing register resets to 0x003e0f0f.
// RULE_10: Registers are little-endian: byte lane 0 is the least significant byte.
// RULE_11: Read-only bits 23..21 report the mode actually in force, coded as the request.
// RULE_12: Restricted mode receives and acknowledges but sends no data, remote, error or overload frames.
// RULE_13: The busy bit reads 1 while the protocol engine is active.
// RULE_14: The mode status changes only once the switch is safely done at a bus-idle point.
// RULE_15: Reserved bits read as zero and ignore writes.
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "cfmc_regs.vh"

// Control registers of two CAN FD controllers; index 0 is the first
// controller, index 1 the second, which also owns the bit-timing register.
module cfmc_top #(
    parameter ADDR_W = 13,
    parameter NCH    = 2
) (
    input  wire              clk_sys,
    input  wire              rst,
    // Avalon-MM slave
    input  wire [ADDR_W-1:0] avs_address,
    input  wire              avs_read,
    input  wire              avs_write,
    input  wire [31:0]       avs_writedata,
    input  wire [3:0]        avs_byteenable,
    output reg  [31:0]       avs_readdata,
    output wire              avs_waitrequest,
    // Protocol engine side; inputs one bit per controller, outputs one field per controller except the bit-timing fields
    input  wire [NCH-1:0]    pe_active,
    input  wire [NCH-1:0]    pe_bus_idle,
    input  wire [NCH-1:0]    tx_pending,
    input  wire [NCH-1:0]    tx_done,
    input  wire [NCH-1:0]    bit_tick,
    output wire [NCH-1:0]    abort_all_tx,
    output wire [NCH-1:0]    tx_gap_hold,
    output wire [3*NCH-1:0]  mode_status,
    output wire [NCH-1:0]    module_on,
    output wire [NCH-1:0]    fd_rx_enable,
    output wire [NCH-1:0]    fd_tx_enable,
    output wire [NCH-1:0]    fd_rx_error,
    output wire [NCH-1:0]    tx_frames_enable,
    output wire [NCH-1:0]    error_frames_enable,
    output wire [NCH-1:0]    listen_only,
    output wire [NCH-1:0]    loopback_internal,
    output wire [NCH-1:0]    loopback_external,
    output wire [NCH-1:0]    tx_queue_enable,
    output wire [NCH-1:0]    tx_event_store_enable,
    output wire [NCH-1:0]    syserr_listen_select,
    output wire [NCH-1:0]    gateway_esi_select,
    output wire [NCH-1:0]    retry_limit_enable,
    output wire [NCH-1:0]    idle_stop,
    output wire [NCH-1:0]    rate_switch_disable,
    output wire [2*NCH-1:0]  wake_filter_time,
    output wire [NCH-1:0]    wake_filter_enable,
    output wire [NCH-1:0]    module_clock_select,
    output wire [NCH-1:0]    protocol_exception_disable,
    output wire [NCH-1:0]    iso_crc_enable,
    output wire [5*NCH-1:0]  devnet_bit_count,
    output wire [7:0]        tq_prescaler,
    output wire [7:0]        time_segment_one,
    output wire [6:0]        time_segment_two,
    output wire [6:0]        sync_jump_width
);
    reg  [31:0] ctrl_r      [0:NCH-1];
    reg  [NCH-1:0] abort_r;
    reg  [31:0] nbt_r;
    reg         ack_r;
    wire [2:0]  stat_w      [0:NCH-1];
    wire [31:0] ctrl_rd_w   [0:NCH-1];
    wire [31:0] nbt_rd_w;
    wire        req_w;
    wire        wr_go;
    wire [31:0] be_mask_w;
    reg  [31:0] rd_nxt;

    // Byte enables to a bit mask; lane 0 is bits 7..0
    function [31:0] lane_mask;
        input [3:0] be;
        begin
            lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}}; // [RULE_10]
        end
    endfunction

    // Merge written lanes into the stored value, only where allowed
    function [31:0] merge;
        input [31:0] old;
        input [31:0] wd;
        input [31:0] lanes;
        input [31:0] allow;
        reg   [31:0] m;
        begin
            m = lanes & allow;
            merge = (old & ~m) | (wd & m);
        end
    endfunction

    // Address decode of each controller's control register
    function is_ctrl;
        input [ADDR_W-1:0] a;
        input integer      ch;
        begin
            if (ch == 0) begin
                is_ctrl = (a == `CFMC_CAN1_CTRL_OFS);
            end else begin
                is_ctrl = (a == `CFMC_CAN2_CTRL_OFS);
            end
        end
    endfunction

    // One wait state: the answer stands in the second cycle of a request
    assign req_w           = avs_read | avs_write;
    assign avs_waitrequest = req_w & ~ack_r;
    assign wr_go           = avs_write & ack_r;
    assign be_mask_w       = lane_mask(avs_byteenable);

    always @(posedge clk_sys) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req_w & ~ack_r;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi = gi + 1) begin : g_ch
            wire       wr_sel;
            wire [31:0] allow;
            wire       in_cfg;

            assign wr_sel = wr_go & is_ctrl(avs_address, gi);
            assign in_cfg = (stat_w[gi] == `CFMC_MODE_CONFIG);
            // Locked fields join the writable set only in configuration mode
            assign allow  = in_cfg ? `CFMC_CTRL_RW_MASK
                                   : (`CFMC_CTRL_RW_MASK & ~`CFMC_CTRL_LOCK_MASK); // [RULE_07]

            // Stored control bits; status, busy and abort are not kept here
            always @(posedge clk_sys) begin
                if (rst) begin
                    ctrl_r[gi] <= `CFMC_CTRL_RESET & `CFMC_CTRL_RW_MASK; // [RULE_08]
                end else if (wr_sel) begin
                    ctrl_r[gi] <= merge(ctrl_r[gi], avs_writedata, be_mask_w, allow); // [RULE_15]
                end
            end

            // Software can only set abort; a set in the clearing cycle wins
            always @(posedge clk_sys) begin
                if (rst) begin
                    abort_r[gi] <= 1'b0;
                end else if (wr_sel && avs_byteenable[3] && avs_writedata[`CFMC_ABORT_BIT]) begin
                    abort_r[gi] <= 1'b1; // [RULE_02]
                end else if (!tx_pending[gi]) begin
                    abort_r[gi] <= 1'b0; // [RULE_03]
                end
            end

            cfmc_mode u_mode (
                .clk_sys       (clk_sys),
                .rst           (rst),
                .mode_request  (ctrl_r[gi][`CFMC_REQ_HI:`CFMC_REQ_LO]),
                .bus_idle      (pe_bus_idle[gi]),
                .mode_status_r (stat_w[gi])
            ); // [RULE_14]

            cfmc_gap u_gap (
                .clk_sys  (clk_sys),
                .rst      (rst),
                .gap_sel  (ctrl_r[gi][`CFMC_GAP_HI:`CFMC_GAP_LO]),
                .tx_done  (tx_done[gi]),
                .bit_tick (bit_tick[gi]),
                .gap_hold (tx_gap_hold[gi])
            ); // [RULE_01]

            // Read view: stored bits plus live abort, status and busy
            assign ctrl_rd_w[gi] = (ctrl_r[gi] & `CFMC_CTRL_RW_MASK)
                                 | ({31'h00000000, abort_r[gi]} << `CFMC_ABORT_BIT)
                                 | ({29'h00000000, stat_w[gi]} << `CFMC_STAT_LO) // [RULE_11]
                                 | ({31'h00000000, pe_active[gi]} << `CFMC_BUSY_BIT); // [RULE_13]

            assign abort_all_tx[gi] = abort_r[gi]; // [RULE_02]
            assign mode_status[3*gi+2:3*gi] = stat_w[gi];

            // Mode decode toward the protocol engine; follows the status,
            // never the request, so the engine only sees completed switches
            assign fd_rx_enable[gi]   = (stat_w[gi] != `CFMC_MODE_CLASSIC)
                                      & (stat_w[gi] != `CFMC_MODE_CONFIG)
                                      & (stat_w[gi] != `CFMC_MODE_DISABLE); // [RULE_06]
            assign fd_tx_enable[gi]   = (stat_w[gi] == `CFMC_MODE_FD)
                                      | (stat_w[gi] == `CFMC_MODE_INT_LOOP)
                                      | (stat_w[gi] == `CFMC_MODE_EXT_LOOP); // [RULE_06]
            assign fd_rx_error[gi]    = (stat_w[gi] == `CFMC_MODE_CLASSIC); // [RULE_05]
            assign tx_frames_enable[gi] = (stat_w[gi] == `CFMC_MODE_FD)
                                        | (stat_w[gi] == `CFMC_MODE_CLASSIC)
                                        | (stat_w[gi] == `CFMC_MODE_INT_LOOP)
                                        | (stat_w[gi] == `CFMC_MODE_EXT_LOOP); // [RULE_12] [RULE_04]
            assign error_frames_enable[gi] = tx_frames_enable[gi]; // [RULE_12]
            assign listen_only[gi]       = (stat_w[gi] == `CFMC_MODE_LISTEN); // [RULE_04]
            assign loopback_internal[gi] = (stat_w[gi] == `CFMC_MODE_INT_LOOP); // [RULE_04]
            assign loopback_external[gi] = (stat_w[gi] == `CFMC_MODE_EXT_LOOP); // [RULE_04]

            // Plain field taps
            assign module_on[gi]             = ctrl_r[gi][`CFMC_ON_BIT];
            assign tx_queue_enable[gi]       = ctrl_r[gi][`CFMC_TXQ_BIT];
            assign tx_event_store_enable[gi] = ctrl_r[gi][`CFMC_TEF_BIT];
            assign syserr_listen_select[gi]  = ctrl_r[gi][`CFMC_SERR_BIT];
            assign gateway_esi_select[gi]    = ctrl_r[gi][`CFMC_ESI_BIT];
            assign retry_limit_enable[gi]    = ctrl_r[gi][`CFMC_RETRY_BIT];
            assign idle_stop[gi]             = ctrl_r[gi][`CFMC_IDLE_STOP_BIT];
            assign rate_switch_disable[gi]   = ctrl_r[gi][`CFMC_BRS_DIS_BIT];
            assign wake_filter_time[2*gi+1:2*gi] = ctrl_r[gi][`CFMC_WFT_HI:`CFMC_WFT_LO];
            assign wake_filter_enable[gi]    = ctrl_r[gi][`CFMC_WAKE_FILTER_ENABLE_BIT];
            assign module_clock_select[gi]   = ctrl_r[gi][`CFMC_CLKSEL_BIT];
            assign protocol_exception_disable[gi] = ctrl_r[gi][`CFMC_PXE_BIT];
            assign iso_crc_enable[gi]        = ctrl_r[gi][`CFMC_ISOCRC_BIT];
            assign devnet_bit_count[5*gi+4:5*gi] = ctrl_r[gi][`CFMC_DEVNET_BIT_COUNT_HI:`CFMC_DEVNET_BIT_COUNT_LO];
        end
    endgenerate

    // Nominal bit timing of the second controller; bits 15 and 7 stay zero
    always @(posedge clk_sys) begin
        if (rst) begin
            nbt_r <= `CFMC_NBT_RESET; // [RULE_09]
        end else if (wr_go && avs_address == `CFMC_CAN2_NBT_OFS) begin
            nbt_r <= merge(nbt_r, avs_writedata, be_mask_w, `CFMC_NBT_RW_MASK); // [RULE_15] [RULE_10]
        end
    end

    assign nbt_rd_w         = nbt_r & `CFMC_NBT_RW_MASK;
    assign tq_prescaler     = nbt_r[31:24];
    assign time_segment_one = nbt_r[23:16];
    assign time_segment_two = nbt_r[14:8];
    assign sync_jump_width  = nbt_r[6:0];

    // Read mux; an unmapped address reads zero
    always @* begin
        if (avs_address == `CFMC_CAN1_CTRL_OFS) begin
            rd_nxt = ctrl_rd_w[0];
        end else if (avs_address == `CFMC_CAN2_CTRL_OFS) begin
            rd_nxt = ctrl_rd_w[NCH-1];
        end else if (avs_address == `CFMC_CAN2_NBT_OFS) begin
            rd_nxt = nbt_rd_w;
        end else begin
            rd_nxt = 32'h00000000;
        end
    end

    // Read data is captured in the first request cycle and held
    always @(posedge clk_sys) begin
        if (rst) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && !ack_r) begin
            avs_readdata <= rd_nxt;
        end
    end
endmodule

/* rtl/cfmc_regs.vh */
`ifndef CFMC_REGS_VH
`define CFMC_REGS_VH

// Register byte offsets
`define CFMC_CAN1_CTRL_OFS   13'h0000
`define CFMC_CAN2_CTRL_OFS   13'h1000
`define CFMC_CAN2_NBT_OFS    13'h1010

// Control register fields
`define CFMC_GAP_HI          31
`define CFMC_GAP_LO          28
`define CFMC_ABORT_BIT       27
`define CFMC_REQ_HI          26
`define CFMC_REQ_LO          24
`define CFMC_STAT_HI         23
`define CFMC_STAT_LO         21
`define CFMC_TXQ_BIT         20
`define CFMC_TEF_BIT         19
`define CFMC_SERR_BIT        18
`define CFMC_ESI_BIT         17
`define CFMC_RETRY_BIT       16
`define CFMC_ON_BIT          15
`define CFMC_IDLE_STOP_BIT   13
`define CFMC_BRS_DIS_BIT     12
`define CFMC_BUSY_BIT        11
`define CFMC_WFT_HI          10
`define CFMC_WFT_LO          9
`define CFMC_WAKE_FILTER_ENABLE_BIT      8
`define CFMC_CLKSEL_BIT      7
`define CFMC_PXE_BIT         6
`define CFMC_ISOCRC_BIT      5
`define CFMC_DEVNET_BIT_COUNT_HI        4
`define CFMC_DEVNET_BIT_COUNT_LO        0

// Stored bits, configuration-locked bits, reset values
`define CFMC_CTRL_RW_MASK    32'hf71fb7ff
`define CFMC_CTRL_LOCK_MASK  32'h001f01e0
`define CFMC_CTRL_RESET      32'h04980760
`define CFMC_NBT_RW_MASK     32'hffff7f7f
`define CFMC_NBT_RESET       32'h003e0f0f

// Mode codes
`define CFMC_MODE_FD         3'h0
`define CFMC_MODE_DISABLE    3'h1
`define CFMC_MODE_INT_LOOP   3'h2
`define CFMC_MODE_LISTEN     3'h3
`define CFMC_MODE_CONFIG     3'h4
`define CFMC_MODE_EXT_LOOP   3'h5
`define CFMC_MODE_CLASSIC    3'h6
`define CFMC_MODE_RESTRICT   3'h7

// Transmit gap: largest code of the doubling range, saturated length
`define CFMC_GAP_LAST_POW    4'hb
`define CFMC_GAP_MAX_BITS    13'h1000

`endif

/* rtl/cfmc_gap.v */
`timescale 1ns/10ps
`include "cfmc_regs.vh"

// Counts the wait between two transmissions in arbitration bit times
module cfmc_gap (
    input  wire       clk_sys,
    input  wire       rst,
    input  wire [3:0] gap_sel,
    input  wire       tx_done,
    input  wire       bit_tick,
    output wire       gap_hold
);
    reg  [12:0] left_r;
    reg  [12:0] left_nxt;

    // Code to length: 0 none, 1..11 doubling from 2, 12..15 saturate
    function [12:0] gap_len;
        input [3:0] code;
        begin
            if (code == 4'h0) begin
                gap_len = 13'h0000;
            end else if (code > `CFMC_GAP_LAST_POW) begin
                gap_len = `CFMC_GAP_MAX_BITS;
            end else begin
                gap_len = 13'h0001 << code;
            end
        end
    endfunction

    // A finished frame reloads; each bit time counts one down
    always @* begin
        left_nxt = left_r;
        if (tx_done) begin
            left_nxt = gap_len(gap_sel); // [RULE_01]
        end else if (bit_tick && left_r != 13'h0000) begin
            left_nxt = left_r - 13'h0001;
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            left_r <= 13'h0000;
        end else begin
            left_r <= left_nxt;
        end
    end

    assign gap_hold = (left_r != 13'h0000); // [RULE_01]
endmodule

/* rtl/cfmc_mode.v */
`timescale 1ns/10ps
`include "cfmc_regs.vh"

// Follows the requested mode, switching only at a bus-idle point
module cfmc_mode (
    input  wire       clk_sys,
    input  wire       rst,
    input  wire [2:0] mode_request,
    input  wire       bus_idle,
    output reg  [2:0] mode_status_r
);
    // Leaving a frame half sent would corrupt the bus, so wait for idle
    always @(posedge clk_sys) begin
        if (rst) begin
            mode_status_r <= `CFMC_MODE_CONFIG;
        end else if (bus_idle && mode_request != mode_status_r) begin
            mode_status_r <= mode_request; // [RULE_14] [RULE_11]
        end
    end
endmodule

/* testbench/cfmc_asserts.sv */
`timescale 1ns/10ps
// Watches the second controller and the shared register bus
module cfmc_asserts #(
    parameter ADDR_W = 13,
    parameter NCH    = 2
) (
    input wire              clk_sys,
    input wire              rst,
    input wire [ADDR_W-1:0] avs_address,
    input wire              avs_read,
    input wire              avs_write,
    input wire [31:0]       avs_writedata,
    input wire [3:0]        avs_byteenable,
    input wire [31:0]       avs_readdata,
    input wire              avs_waitrequest,
    input wire [NCH-1:0]    pe_active,
    input wire [NCH-1:0]    pe_bus_idle,
    input wire [NCH-1:0]    tx_pending,
    input wire [NCH-1:0]    bit_tick,
    input wire [NCH-1:0]    abort_all_tx,
    input wire [NCH-1:0]    tx_gap_hold,
    input wire [3*NCH-1:0]  mode_status,
    input wire [NCH-1:0]    fd_rx_enable,
    input wire [NCH-1:0]    fd_tx_enable,
    input wire [NCH-1:0]    fd_rx_error,
    input wire [NCH-1:0]    tx_frames_enable,
    input wire [NCH-1:0]    error_frames_enable
);
    // Completed accesses; the address is held for the whole transfer
    wire rd_ok = avs_read && !avs_waitrequest;
    wire at_c2 = avs_address == 13'h1000;
    wire at_nb = avs_address == 13'h1010;
    wire ab_set = avs_write && !avs_waitrequest && at_c2 && avs_byteenable[3] && avs_writedata[27];
    wire [2:0] st = mode_status[5:3];

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_one_wait; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait state too long");
    property p_abort_set; ab_set |=> abort_all_tx[1]; endproperty
    a_abort_set: assert property (p_abort_set) else $error("abort not raised");
    property p_abort_clr; abort_all_tx[1] && !tx_pending[1] && !ab_set |=> !abort_all_tx[1]; endproperty
    a_abort_clr: assert property (p_abort_clr) else $error("abort not cleared");
    // Past reset is excluded: reset drops the flag whatever is pending
    property p_abort_hold; $fell(abort_all_tx[1]) && !$past(rst) |-> !$past(tx_pending[1]); endproperty
    a_abort_hold: assert property (p_abort_hold) else $error("abort cleared early");
    property p_mode_idle; !$stable(st) && !$past(rst) |-> $past(pe_bus_idle[1]); endproperty
    a_mode_idle: assert property (p_mode_idle) else $error("mode moved off idle");
    property p_busy_rd; rd_ok && at_c2 |-> avs_readdata[11] == $past(pe_active[1]); endproperty
    a_busy_rd: assert property (p_busy_rd) else $error("busy bit wrong");
    property p_stat_rd; rd_ok && at_c2 |-> avs_readdata[23:21] == $past(st); endproperty
    a_stat_rd: assert property (p_stat_rd) else $error("status field wrong");
    property p_resv; rd_ok |-> !(at_c2 && avs_readdata[14]) && !(at_nb && (avs_readdata[15] || avs_readdata[7])); endproperty
    a_resv: assert property (p_resv) else $error("reserved bit set");
    property p_gap_end; $fell(tx_gap_hold[1]) && !$past(rst) |-> $past(bit_tick[1]); endproperty
    a_gap_end: assert property (p_gap_end) else $error("gap ended without tick");
    property p_restrict; st == 3'h7 |-> !tx_frames_enable[1] && !error_frames_enable[1]; endproperty
    a_restrict: assert property (p_restrict) else $error("restricted mode sends");
    property p_classic; st == 3'h6 |-> fd_rx_error[1] && !fd_tx_enable[1]; endproperty
    a_classic: assert property (p_classic) else $error("classic mode takes fd");
    property p_fd; st == 3'h0 |-> fd_rx_enable[1] && fd_tx_enable[1] && tx_frames_enable[1]; endproperty
    a_fd: assert property (p_fd) else $error("fd mode not mixed");

    c_abort: cover property ($fell(abort_all_tx[1]));
    c_mode: cover property (!$stable(st));
    c_gap: cover property ($rose(tx_gap_hold[1]));
endmodule

bind cfmc_top cfmc_asserts #(.ADDR_W(ADDR_W), .NCH(NCH)) u_chk (.clk_sys(clk_sys), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pe_active(pe_active), .pe_bus_idle(pe_bus_idle), .tx_pending(tx_pending), .bit_tick(bit_tick),
    .abort_all_tx(abort_all_tx), .tx_gap_hold(tx_gap_hold), .mode_status(mode_status),
    .fd_rx_enable(fd_rx_enable), .fd_tx_enable(fd_tx_enable), .fd_rx_error(fd_rx_error),
    .tx_frames_enable(tx_frames_enable), .error_frames_enable(error_frames_enable));

/* testbench/cfmc_pe_model.sv */
`timescale 1ns/10ps
// Protocol engine stand-in; the first engine is parked idle so mix-ups show
module cfmc_pe_model (
    input  wire       clk_sys,
    input  wire       busy,
    input  wire       idle,
    input  wire       pend,
    input  wire       send,
    input  wire       tick_en,
    output wire [1:0] pe_active,
    output wire [1:0] pe_bus_idle,
    output wire [1:0] tx_pending,
    output reg  [1:0] tx_done = 2'h0,
    output reg  [1:0] bit_tick = 2'h0
);
    assign pe_active   = {busy, 1'b0};
    assign pe_bus_idle = {idle, 1'b1};
    assign tx_pending  = {pend, 1'b0};
    // Pulses launched just after an edge, one bit time per cycle
    always @(posedge clk_sys) begin
        tx_done  <= {send, 1'b0};
        bit_tick <= {tick_en, 1'b0};
    end
endmodule

/* testbench/can_fd_mode_control_tb.sv */
`timescale 1ns/10ps
module can_fd_mode_control_tb;
    reg         clk_sys = 1'b0;
    reg         rst = 1'b1;
    reg  [12:0] avs_address = 13'h0000;
    reg         avs_read = 1'b0;
    reg         avs_write = 1'b0;
    reg  [31:0] avs_writedata = 32'h00000000;
    reg  [3:0]  avs_byteenable = 4'hf;
    reg         busy = 1'b0;
    reg         idle = 1'b1;
    reg         pend = 1'b0;
    reg         send = 1'b0;
    reg         tick_en = 1'b1;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest;
    wire [1:0]  pe_active, pe_bus_idle, tx_pending, tx_done, bit_tick;
    wire [1:0]  abort_all_tx, tx_gap_hold, tx_queue_enable;
    wire [5:0]  mode_status;
    integer     miscompares = 0;
    integer     n_checks = 0;
    integer     i;
    integer     n;
    reg  [31:0] rd;

    always #5 clk_sys = ~clk_sys;

    cfmc_pe_model u_pe (.clk_sys(clk_sys), .busy(busy), .idle(idle), .pend(pend), .send(send),
        .tick_en(tick_en), .pe_active(pe_active), .pe_bus_idle(pe_bus_idle), .tx_pending(tx_pending),
        .tx_done(tx_done), .bit_tick(bit_tick));

    cfmc_top DUT (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pe_active(pe_active),
        .pe_bus_idle(pe_bus_idle), .tx_pending(tx_pending), .tx_done(tx_done), .bit_tick(bit_tick),
        .abort_all_tx(abort_all_tx), .tx_gap_hold(tx_gap_hold), .mode_status(mode_status), .module_on(),
        .fd_rx_enable(), .fd_tx_enable(), .fd_rx_error(), .tx_frames_enable(), .error_frames_enable(),
        .listen_only(), .loopback_internal(), .loopback_external(), .tx_queue_enable(tx_queue_enable),
        .tx_event_store_enable(), .syserr_listen_select(), .gateway_esi_select(), .retry_limit_enable(),
        .idle_stop(), .rate_switch_disable(), .wake_filter_time(), .wake_filter_enable(),
        .module_clock_select(), .protocol_exception_disable(), .iso_crc_enable(), .devnet_bit_count(),
        .tq_prescaler(), .time_segment_one(), .time_segment_two(), .sync_jump_width());

    task conclude;
        begin
            $display("checks %0d mismatches %0d", n_checks, miscompares);
            if (miscompares == 0 && n_checks > 0) begin
                $display("Result: passed");
            end else begin
                $display("Result: failed");
            end
            $finish;
        end
    endtask

    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("[ERR] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask

    // One transfer; the request stands until waitrequest is seen low
    task bus(input w, input [12:0] a, input [31:0] d, input [3:0] be);
        integer k;
        begin
            @(posedge clk_sys);
            avs_address <= a;
            avs_writedata <= d;
            avs_byteenable <= be;
            avs_write <= w;
            avs_read <= !w;
            k = 0;
            @(posedge clk_sys);
            while (avs_waitrequest !== 1'b0 && k < 20) begin
                @(posedge clk_sys);
                k = k + 1;
            end
            if (k == 20) begin
                chk(32'h0, 32'h1);
                conclude;
            end
            rd = avs_readdata;
            avs_write <= 1'b0;
            avs_read <= 1'b0;
        end
    endtask

    // Mode follows only at a bus-idle point, so the wait is bounded
    task wait_mode(input [2:0] m);
        integer k;
        begin
            k = 0;
            while (mode_status[5:3] !== m && k < 20) begin
                @(posedge clk_sys);
                k = k + 1;
            end
            chk({29'h0, mode_status[5:3]}, {29'h0, m});
        end
    endtask

    task t_reset;
        begin
            bus(0, 13'h1000, 0, 4'hf);
            chk(rd, 32'h04980760);
            bus(0, 13'h1010, 0, 4'hf);
            chk(rd, 32'h003e0f0f);
            bus(0, 13'h0ffc, 0, 4'hf);
            chk(rd, 32'h0);
            bus(0, 13'h0000, 0, 4'hf);
            chk(rd, 32'h04980760);
            busy <= 1'b1;
            bus(0, 13'h1000, 0, 4'hf);
            chk(rd, 32'h04980f60);
            busy <= 1'b0;
        end
    endtask

    task t_lanes;
        begin
            bus(1, 13'h1010, 32'h11223344, 4'h1);
            bus(0, 13'h1010, 0, 4'hf);
            chk(rd, 32'h003e0f44);
            bus(1, 13'h1010, 32'haabbccdd, 4'h8);
            bus(0, 13'h1010, 0, 4'hf);
            chk(rd, 32'haa3e0f44);
            bus(1, 13'h1010, 32'hffffffff, 4'hf);
            bus(0, 13'h1010, 0, 4'hf);
            chk(rd, 32'hffff7f7f);
        end
    endtask

    task t_lock;
        begin
            bus(1, 13'h1000, 32'h04000000, 4'hf);
            bus(0, 13'h1000, 0, 4'hf);
            chk(rd, 32'h04800000);
            bus(1, 13'h1000, 32'h00100000, 4'hf);
            wait_mode(3'h0);
            bus(0, 13'h1000, 0, 4'hf);
            chk(rd, 32'h00100000);
            bus(1, 13'h1000, 32'h04000000, 4'hf);
            wait_mode(3'h4);
            bus(0, 13'h1000, 0, 4'hf);
            chk(rd, 32'h04900000);
            chk({31'h0, tx_queue_enable[1]}, 32'h1);
        end
    endtask

    task t_modes;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                idle <= 1'b0;
                bus(1, 13'h1000, i << 24, 4'hf);
                repeat (4) @(posedge clk_sys);
                chk({29'h0, mode_status[5:3]}, (i == 0) ? 4 : i - 1);
                idle <= 1'b1;
                wait_mode(i);
                bus(0, 13'h1000, 0, 4'hf);
                chk({26'h0, rd[26:21]}, i * 9);
            end
        end
    endtask

    task t_abort;
        begin
            pend <= 1'b1;
            bus(1, 13'h1000, 32'h0f000000, 4'hf);
            bus(0, 13'h1000, 0, 4'hf);
            chk({31'h0, rd[27]}, 32'h1);
            bus(1, 13'h1000, 32'h07000000, 4'hf);
            bus(0, 13'h1000, 0, 4'hf);
            chk({31'h0, rd[27]}, 32'h1);
            chk({31'h0, abort_all_tx[1]}, 32'h1);
            pend <= 1'b0;
            bus(0, 13'h1000, 0, 4'hf);
            chk({31'h0, rd[27]}, 32'h0);
        end
    endtask

    // Every gap code; the gap is timed in cycles since a bit passes each cycle
    task t_gap;
        begin
            for (i = 0; i < 16; i = i + 1) begin
                bus(1, 13'h1000, (i << 28) | 32'h07000000, 4'hf);
                send <= 1'b1;
                @(posedge clk_sys);
                send <= 1'b0;
                repeat (2) @(posedge clk_sys);
                n = 0;
                while (tx_gap_hold[1] === 1'b1 && n < 5000) begin
                    n = n + 1;
                    @(posedge clk_sys);
                end
                chk(n, (i == 0) ? 0 : (i >= 12) ? 4096 : (1 << i));
            end
        end
    endtask

    initial begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset;
        t_lanes;
        t_lock;
        t_modes;
        t_abort;
        t_gap;
        conclude;
    end
endmodule
